//--- color_sensor_pkg.sv
// Constants, types and state layout for the color sensor control register bank.
package color_sensor_pkg;

  // Register offsets on the serial register bus.
  localparam logic [7:0] OFS_CHIP_IDENTITY = 8'h01;
  localparam logic [7:0] OFS_POWER_LEVEL_CTRL = 8'h04;
  localparam logic [7:0] OFS_CHIP_REVISION = 8'h11;
  localparam logic [7:0] OFS_IRQ_PIN_SETUP = 8'h22;
  localparam logic [7:0] OFS_INIT_CONFIG_A = 8'h70;
  localparam logic [7:0] OFS_INIT_CONFIG_B = 8'h71;
  localparam logic [7:0] OFS_INDICATOR_LED_CTRL = 8'h84;
  localparam logic [7:0] OFS_INIT_CONFIG_D = 8'h88;
  localparam logic [7:0] OFS_INIT_CONFIG_E = 8'h9A;
  localparam logic [7:0] OFS_INIT_CONFIG_C = 8'hB0;
  localparam logic [7:0] OFS_SHUTTER_DRIVER_CTRL = 8'hEA;
  localparam logic [7:0] OFS_IRQ_CLEAR_CTRL = 8'hF8;
  localparam logic [7:0] OFS_READY_NOTIFY_CTRL = 8'hF9;

  // Reset values.
  localparam logic [7:0] RST_POWER_LEVEL_CTRL = 8'h02;
  localparam logic [7:0] RST_IRQ_PIN_SETUP = 8'h00;
  localparam logic [7:0] RST_OTHER = 8'h00;

  // Field positions.
  localparam int POWER_LEVEL_SELECT_BIT = 1;
  localparam int IRQ_CLEAR_BIT = 2;
  localparam int NOTIFY_EN_MSB = 2;
  localparam int NOTIFY_EN_LSB = 1;
  localparam int SHUTTER_ON_BIT = 2;
  localparam int INDICATOR_CURRENT_MSB = 3;
  localparam int INDICATOR_CURRENT_LSB = 2;
  localparam int INDICATOR_ON_BIT = 0;

  // Interrupt pin setup code that enables the pin.
  localparam logic [7:0] IRQ_PIN_ENABLE_CODE = 8'hCA;

  // Bits in one serial byte.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK = 4'h8
  } serial_state_t;

  // LED driver outputs.
  typedef struct packed {
    logic shutter_on;
    logic [1:0] shutter_limit;
    logic indicator_on;
    logic [1:0] indicator_current;
  } led_out_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic [7:0] power;
    logic [7:0] irq_pin;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] cfg_c;
    logic [7:0] cfg_d;
    logic [7:0] cfg_e;
    logic [7:0] indicator;
    logic [7:0] shutter;
    logic [7:0] irq_clear;
    logic [7:0] notify;
    logic ready_flag;
    logic irq;
    led_out_t led;
    serial_state_t state;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rw;
    logic sda_drive;
    logic scl_q;
    logic sda_q;
  } bank_state_t;

endpackage

//--- color_sensor_control_registers.sv
// Serial target and control register bank of the color sensor.
`timescale 1ns/100ps

// Bus overview.
// The host reaches the bank over a two-wire serial bus: a clock line that only the host
// drives and a shared data line with a pull-up that either side may pull low.
// Both lines are sampled on the system clock and treated as synchronous to it, so the host
// must leave at least two system clocks between any two line edges.
// A start is a falling data line while the bus clock stays high.
// A stop is a rising data line while the bus clock stays high.
// Either one may come at any time and takes priority over the byte engine.
// Each byte travels most significant bit first.
// Data bits are taken one clock after the bus clock is seen high.
// The data line may only change while the bus clock is low.
// After the eighth bit the bank pulls the data line low for one bit time to acknowledge.
// The acknowledge starts one clock after the following bus clock fall.
// It ends one clock after the next bus clock fall.
// A write frame carries the target address with the write bit, then the register pointer,
// then any number of data bytes.
// Each data byte lands in the register that the pointer names.
// The pointer then moves on by one, wrapping from the top address to zero.
// A read frame sets the pointer as a write would, then repeats the start with the read bit.
// The bank then shifts out the addressed byte and moves the pointer on after each byte.
// An acknowledge from the host asks for the next byte.
// A missing acknowledge from the host ends the read.
// An address that is not ours is left unanswered until the next start.
// Writes to the identity and revision bytes are acknowledged but change nothing.
// Writes to addresses outside the map are acknowledged but change nothing.
// Reads of addresses outside the map return zero.

// Register map, offset then contents.
// Offset 0x01 holds the fixed identity byte, read only.
// Offset 0x04 holds the power level, with bit 1 high for normal operation.
// Offset 0x11 holds the fixed revision byte, read only.
// Offset 0x22 holds the interrupt pin setup; the pin works only with the enable code.
// Offsets 0x70, 0x71, 0xB0, 0x88 and 0x9A hold the configuration bytes.
// Offset 0x84 holds the indicator: bit 0 switches it on, bits 3:2 pick its current.
// Offset 0xEA holds the shutter driver: bit 2 switches it on.
// Offset 0xF8 holds the interrupt clear: bit 2 drops the ready flag while notification is enabled.
// Offset 0xF9 holds the ready notification enable in bits 2:1.

// Hazards and limits.
// The bank never stretches the bus clock.
// The host must therefore keep each low phase long enough for a read bit to settle.
// Reserved bits are stored as written and read back as written.
// A host that writes reserved bits as zero therefore always reads zero there.
// The configuration bytes have no effect inside this block; they are only held.
// The ready flag is sticky: it stays set until the host clears it.
// A ready event in the same cycle as a clear wins, so no event is lost.
module color_sensor_control_registers #(
  parameter logic [6:0] TARGET_ADDR = 7'h2A,
  parameter logic [7:0] CHIP_IDENTITY = 8'h5A, // Value is arbitrary.
  parameter logic [7:0] CHIP_REVISION = 8'h01 // Value is arbitrary.
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b_o,
  input wire logic channel_ready_i,
  input wire logic [1:0] gain_drive_limit_i,
  output logic power_normal_o,
  output color_sensor_pkg::led_out_t led_o,
  output logic data_ready_o,
  output logic irq_o
);

  // Registered state and its next value.
  color_sensor_pkg::bank_state_t s_q;
  color_sensor_pkg::bank_state_t s_d;

  // Bus line events decoded from the sampled levels.
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  // Register write strobe, address and data from the byte engine, and the read byte.
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;

  // Tells whether the notify field enables data ready signalling.
  // Either bit of the two-bit field counts as enabled.
  // The same test gates the ready flag, the clear and the clear bit read-back.
  function automatic logic notify_on(input logic [7:0] v);
    notify_on = |v[color_sensor_pkg::NOTIFY_EN_MSB:color_sensor_pkg::NOTIFY_EN_LSB];
  endfunction

  // Returns the byte that a read at the given address shows.
  // Read data comes from the registered state, so a read after a write sees the new value.
  // The clear bit is forced high while notification is enabled so that a host can poll it.
  // Addresses outside the map read as zero.
  function automatic logic [7:0] read_reg(input logic [7:0] a,
                                          input color_sensor_pkg::bank_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      color_sensor_pkg::OFS_CHIP_IDENTITY: v = CHIP_IDENTITY;
      color_sensor_pkg::OFS_CHIP_REVISION: v = CHIP_REVISION;
      color_sensor_pkg::OFS_POWER_LEVEL_CTRL: v = s.power;
      color_sensor_pkg::OFS_IRQ_PIN_SETUP: v = s.irq_pin;
      color_sensor_pkg::OFS_INIT_CONFIG_A: v = s.cfg_a;
      color_sensor_pkg::OFS_INIT_CONFIG_B: v = s.cfg_b;
      color_sensor_pkg::OFS_INIT_CONFIG_C: v = s.cfg_c;
      color_sensor_pkg::OFS_INIT_CONFIG_D: v = s.cfg_d;
      color_sensor_pkg::OFS_INIT_CONFIG_E: v = s.cfg_e;
      color_sensor_pkg::OFS_INDICATOR_LED_CTRL: v = s.indicator;
      color_sensor_pkg::OFS_SHUTTER_DRIVER_CTRL: v = s.shutter;
      color_sensor_pkg::OFS_IRQ_CLEAR_CTRL: begin
        v = s.irq_clear;
        if (notify_on(s.notify)) begin
          v[color_sensor_pkg::IRQ_CLEAR_BIT] = 1'b1;
        end
      end
      color_sensor_pkg::OFS_READY_NOTIFY_CTRL: v = s.notify;
      default: v = 8'h00;
    endcase
    read_reg = v;
  endfunction

  // Bus line events, seen against the levels of the previous cycle.
  assign start_seen = scl_i & s_q.scl_q & s_q.sda_q & ~sda_i;
  assign stop_seen = scl_i & s_q.scl_q & ~s_q.sda_q & sda_i;
  assign scl_rise = scl_i & ~s_q.scl_q;
  assign scl_fall = ~scl_i & s_q.scl_q;
  assign rd_byte = read_reg(s_q.ptr, s_q);

  // Serial target, register writes and ready flag.
  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_addr = s_q.ptr;
    wr_data = s_q.shift;
    s_d.scl_q = scl_i;
    s_d.sda_q = sda_i;
    // A start or a stop overrides whatever the byte engine is doing.
    // A repeated start in the middle of a frame restarts the address phase.
    if (start_seen) begin
      s_d.state = color_sensor_pkg::ST_ADDR;
      s_d.cnt = 4'h0;
      s_d.sda_drive = 1'b0;
    end else if (stop_seen) begin
      s_d.state = color_sensor_pkg::ST_IDLE;
      s_d.sda_drive = 1'b0;
    end else begin
      case (s_q.state)
        // Idle: wait for a start with the data line left to the pull-up.
        color_sensor_pkg::ST_IDLE: begin
          s_d.sda_drive = 1'b0;
        end
        // Byte receive: address, pointer and write data share one shifter.
        // Bits are counted on each bus clock rise.
        // The acknowledge is raised on the fall after the eighth bit, never while the clock is high.
        color_sensor_pkg::ST_ADDR,
        color_sensor_pkg::ST_REG,
        color_sensor_pkg::ST_WDATA: begin
          if (scl_rise && s_q.cnt < color_sensor_pkg::BYTE_BITS) begin
            s_d.shift = {s_q.shift[6:0], sda_i};
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (scl_fall && s_q.cnt == color_sensor_pkg::BYTE_BITS) begin
            s_d.cnt = 4'h0;
            s_d.sda_drive = 1'b1;
            if (s_q.state == color_sensor_pkg::ST_ADDR) begin
              if (s_q.shift[7:1] == TARGET_ADDR) begin
                s_d.rw = s_q.shift[0];
                s_d.state = color_sensor_pkg::ST_ADDR_ACK;
              end else begin
                s_d.sda_drive = 1'b0;
                s_d.state = color_sensor_pkg::ST_IDLE;
              end
            end else if (s_q.state == color_sensor_pkg::ST_REG) begin
              s_d.ptr = s_q.shift;
              s_d.state = color_sensor_pkg::ST_REG_ACK;
            end else begin
              wr_en = 1'b1;
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.state = color_sensor_pkg::ST_WDATA_ACK;
            end
          end
        end
        // Address acknowledge: its closing fall starts a read byte or the pointer phase.
        color_sensor_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (s_q.rw) begin
              s_d.shift = rd_byte;
              s_d.sda_drive = ~rd_byte[7];
              s_d.state = color_sensor_pkg::ST_RDATA;
            end else begin
              s_d.sda_drive = 1'b0;
              s_d.state = color_sensor_pkg::ST_REG;
            end
          end
        end
        // Pointer and data acknowledges: release the line and take further data bytes.
        color_sensor_pkg::ST_REG_ACK,
        color_sensor_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            s_d.sda_drive = 1'b0;
            s_d.state = color_sensor_pkg::ST_WDATA;
          end
        end
        // Read byte: the line is pulled low for each zero bit and released for each one bit.
        // The next bit is put out one clock after each bus clock fall.
        color_sensor_pkg::ST_RDATA: begin
          if (scl_rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
          end
          if (scl_fall) begin
            if (s_q.cnt == color_sensor_pkg::BYTE_BITS) begin
              s_d.sda_drive = 1'b0;
              s_d.cnt = 4'h0;
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.state = color_sensor_pkg::ST_RACK;
            end else begin
              s_d.shift = {s_q.shift[6:0], 1'b0};
              s_d.sda_drive = ~s_q.shift[6];
            end
          end
        end
        // Host answer: a high line at the rise ends the read, otherwise the next byte follows.
        color_sensor_pkg::ST_RACK: begin
          if (scl_rise && sda_i) begin
            s_d.state = color_sensor_pkg::ST_IDLE;
          end else if (scl_fall) begin
            s_d.shift = rd_byte;
            s_d.sda_drive = ~rd_byte[7];
            s_d.state = color_sensor_pkg::ST_RDATA;
          end
        end
        // Any unknown state falls back to idle with the line released.
        default: begin
          s_d.state = color_sensor_pkg::ST_IDLE;
          s_d.sda_drive = 1'b0;
        end
      endcase
    end

    // Register writes; read-only and unlisted addresses are ignored.
    // A write lands on the fall that follows the eighth data bit, together with the acknowledge.
    // The whole byte is stored, reserved bits included, so reads return what was written, apart from the clear bit forced high while notification is enabled.
    // A clear only acts while notification is enabled; otherwise it is merely stored.
    if (wr_en) begin
      case (wr_addr)
        color_sensor_pkg::OFS_POWER_LEVEL_CTRL: s_d.power = wr_data;
        color_sensor_pkg::OFS_IRQ_PIN_SETUP: s_d.irq_pin = wr_data;
        color_sensor_pkg::OFS_INIT_CONFIG_A: s_d.cfg_a = wr_data;
        color_sensor_pkg::OFS_INIT_CONFIG_B: s_d.cfg_b = wr_data;
        color_sensor_pkg::OFS_INIT_CONFIG_C: s_d.cfg_c = wr_data;
        color_sensor_pkg::OFS_INIT_CONFIG_D: s_d.cfg_d = wr_data;
        color_sensor_pkg::OFS_INIT_CONFIG_E: s_d.cfg_e = wr_data;
        color_sensor_pkg::OFS_INDICATOR_LED_CTRL: s_d.indicator = wr_data;
        color_sensor_pkg::OFS_SHUTTER_DRIVER_CTRL: s_d.shutter = wr_data;
        color_sensor_pkg::OFS_READY_NOTIFY_CTRL: s_d.notify = wr_data;
        color_sensor_pkg::OFS_IRQ_CLEAR_CTRL: begin
          s_d.irq_clear = wr_data;
          if (wr_data[color_sensor_pkg::IRQ_CLEAR_BIT] && notify_on(s_q.notify)) begin
            s_d.ready_flag = 1'b0;
          end
        end
        default: s_d.ptr = s_d.ptr;
      endcase
    end

    // A ready event in the same cycle as a clear keeps the flag set.
    // Ready events while notification is disabled are dropped, not held back.
    if (channel_ready_i && notify_on(s_q.notify)) begin
      s_d.ready_flag = 1'b1;
    end

    // Interrupt pin only asserts when set up with the enable code.
    // It is built from the next flag value so that flag and pin move in the same cycle.
    s_d.irq = s_d.ready_flag && (s_d.irq_pin == color_sensor_pkg::IRQ_PIN_ENABLE_CODE);

    // LED driver outputs follow their control registers.
    // They are built from the next register values and so move with the register itself.
    // The shutter limit is only passed through; the gain and drive setting lives elsewhere.
    s_d.led.shutter_on = s_d.shutter[color_sensor_pkg::SHUTTER_ON_BIT];
    s_d.led.shutter_limit = gain_drive_limit_i;
    s_d.led.indicator_on = s_d.indicator[color_sensor_pkg::INDICATOR_ON_BIT];
    s_d.led.indicator_current = s_d.indicator[color_sensor_pkg::INDICATOR_CURRENT_MSB:
                                              color_sensor_pkg::INDICATOR_CURRENT_LSB];
  end

  // State register with synchronous reset.
  // All registers clear except the power byte, which comes up in normal operation, and the two sampled bus levels.
  // The sampled bus levels reset high, the idle level of both lines, so no false start follows.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
      s_q.power <= color_sensor_pkg::RST_POWER_LEVEL_CTRL;
      s_q.irq_pin <= color_sensor_pkg::RST_IRQ_PIN_SETUP;
      s_q.notify <= color_sensor_pkg::RST_OTHER;
      s_q.indicator <= color_sensor_pkg::RST_OTHER;
      s_q.scl_q <= 1'b1;
      s_q.sda_q <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Open-drain data line: only ever pulled low.
  // The enable is registered, so the line never glitches while the bus clock is high.
  assign sda_o = 1'b0;
  assign sda_oe_b_o = ~s_q.sda_drive;
  assign power_normal_o = s_q.power[color_sensor_pkg::POWER_LEVEL_SELECT_BIT];
  assign led_o = s_q.led;
  assign data_ready_o = s_q.ready_flag;
  assign irq_o = s_q.irq;

endmodule

//--- color_sensor_control_registers_asserts.sv
// Port assertions and covers for the color sensor register bank.
`timescale 1ns/100ps
module color_sensor_control_registers_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_b_o,
  input wire logic channel_ready_i,
  input wire logic [1:0] gain_drive_limit_i,
  input wire logic power_normal_o,
  input wire color_sensor_pkg::led_out_t led_o,
  input wire logic data_ready_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Outputs leave reset at their documented values.
  property p_reset_vals;
    !$past(rst_b_i) |-> sda_oe_b_o && power_normal_o && led_o == 6'h00 && !irq_o;
  endproperty
  // The interrupt only stands while the ready flag stands; both come from one register update.
  property p_irq_src;
    irq_o |-> data_ready_o;
  endproperty
  // The interrupt drops only after the flag drops or a register write.
  property p_irq_fall;
    $fell(irq_o) |-> !$past(data_ready_o) || !sda_oe_b_o || $past(!sda_oe_b_o);
  endproperty
  // The flag rises only on a ready event.
  property p_ready_set;
    $rose(data_ready_o) |-> $past(channel_ready_i);
  endproperty
  // The flag clears only at a write acknowledge and a ready event wins.
  property p_ready_clr;
    $fell(data_ready_o) |-> !$past(channel_ready_i) && !sda_oe_b_o;
  endproperty
  // A driver that is on carries the limit input one cycle late.
  property p_limit;
    $past(rst_b_i) && led_o.shutter_on |-> led_o.shutter_limit == $past(gain_drive_limit_i);
  endproperty
  // Power mode moves only when a written byte is acknowledged.
  property p_power_wr;
    $past(rst_b_i) && $changed(power_normal_o) |-> !sda_oe_b_o;
  endproperty
  // LED switches and current move only when a written byte is acknowledged.
  property p_led_wr;
    $past(rst_b_i) && $changed({led_o.shutter_on, led_o.indicator_on, led_o.indicator_current})
      |-> !sda_oe_b_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
  a_irq_src: assert property (p_irq_src) else $error("interrupt without flag");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped alone");
  a_ready_set: assert property (p_ready_set) else $error("flag set without event");
  a_ready_clr: assert property (p_ready_clr) else $error("flag cleared wrongly");
  a_limit: assert property (p_limit) else $error("driver limit wrong");
  a_power_wr: assert property (p_power_wr) else $error("power moved alone");
  a_led_wr: assert property (p_led_wr) else $error("led moved alone");
  // Main scenarios.
  c_irq: cover property ($rose(irq_o));
  c_clr: cover property ($fell(data_ready_o));
  c_low_power: cover property ($fell(power_normal_o));
  c_shutter: cover property ($rose(led_o.shutter_on));
endmodule
bind color_sensor_control_registers color_sensor_control_registers_asserts i_asserts (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_b_o(sda_oe_b_o), .channel_ready_i(channel_ready_i),
  .gain_drive_limit_i(gain_drive_limit_i), .power_normal_o(power_normal_o),
  .led_o(led_o), .data_ready_o(data_ready_o), .irq_o(irq_o));

//--- color_sensor_host_model.sv
// Behavioural serial host that loads and reads the register bank.
`timescale 1ns/100ps
module color_sensor_host_model #(
  parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
  input wire logic clk_i,
  input wire logic dev_oe_b_i,
  output logic scl_o,
  output logic sda_o
);
  logic sda_drv;
  // Open-drain wire with pull-up: low when either side pulls it.
  assign sda_o = sda_drv & dev_oe_b_i;
  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end
  // One bus phase lasts three clocks so that no two edges come close.
  task automatic ph(input logic c, input logic d);
    @(posedge clk_i);
    scl_o <= c;
    sda_drv <= d;
    repeat (2) @(posedge clk_i);
  endtask
  // Data moves only while the clock is low; the wire is taken late in the high phase.
  task automatic bit_x(input logic b, output logic r);
    ph(1'b0, sda_drv);
    ph(1'b0, b);
    ph(1'b1, b);
    #1 r = sda_o;
  endtask
  task automatic start();
    ph(1'b0, sda_drv);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic stop();
    ph(1'b0, sda_drv);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Eight bits first to last, then the acknowledge bit.
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ab, a);
  endtask
  // Pointer then one data byte; nak gathers any missing acknowledge.
  task automatic wr(input logic [7:0] ra, input logic [7:0] d, output logic nak);
    logic [7:0] x;
    logic a0, a1, a2;
    start();
    xfer({TARGET_ADDR, 1'b0}, 1'b1, x, a0);
    xfer(ra, 1'b1, x, a1);
    xfer(d, 1'b1, x, a2);
    stop();
    nak = a0 | a1 | a2;
  endtask
  // Pointer, repeated start, one byte read that ends with a not-acknowledge.
  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic nak);
    logic [7:0] x;
    logic a0, a1, a2, a3;
    start();
    xfer({TARGET_ADDR, 1'b0}, 1'b1, x, a0);
    xfer(ra, 1'b1, x, a1);
    start();
    xfer({TARGET_ADDR, 1'b1}, 1'b1, x, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    nak = a0 | a1 | a2;
  endtask
endmodule

//--- color_sensor_control_registers_tb.sv
// Self-checking bench for the color sensor register bank.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module color_sensor_control_registers_tb;
  localparam logic [7:0] ID = 8'hC3; // Value is arbitrary.
  localparam logic [7:0] REV = 8'h07; // Value is arbitrary.
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic channel_ready_i = 1'b0;
  logic [1:0] gain_drive_limit_i = 2'h0;
  logic scl, sda, sda_o, sda_oe_b_o, power_normal_o, data_ready_o, irq_o, nak;
  logic [7:0] rv;
  color_sensor_pkg::led_out_t led_o;
  int bad_count = 0;
  int n_checks = 0;
  always #50 clk_i = ~clk_i;
  color_sensor_control_registers #(.CHIP_IDENTITY(ID), .CHIP_REVISION(REV))
    i_color_sensor_control_registers (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b_o), .channel_ready_i(channel_ready_i),
    .gain_drive_limit_i(gain_drive_limit_i), .power_normal_o(power_normal_o),
    .led_o(led_o), .data_ready_o(data_ready_o), .irq_o(irq_o));
  color_sensor_host_model i_color_sensor_host_model (
    .clk_i(clk_i), .dev_oe_b_i(sda_oe_b_o), .scl_o(scl), .sda_o(sda));
  // Register write and read compare through the host, acknowledges included.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_color_sensor_host_model.wr(a, d, nak);
    `CHK("ack", 1'b0, nak)
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] ex);
    i_color_sensor_host_model.rd(a, rv, nak);
    `CHK("ack", 1'b0, nak)
    `CHK("read", ex, rv)
  endtask
  // One-cycle ready event, then time for the flag and interrupt to settle.
  task automatic pulse();
    @(posedge clk_i);
    channel_ready_i <= 1'b1;
    @(posedge clk_i);
    channel_ready_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic t_reset();
    `CHK("power", 1'b1, power_normal_o)
    `CHK("led", 6'h00, led_o)
    `CHK("sda_o", 1'b0, sda_o)
    rc(8'h04, 8'h02);
    rc(8'h22, 8'h00);
    rc(8'hF9, 8'h00);
    rc(8'h84, 8'h00);
    $display("test reset done");
  endtask
  // Read-only bytes ignore writes; an unlisted address reads zero.
  task automatic t_ro();
    wr(8'h01, 8'hFF);
    wr(8'h11, 8'hFF);
    rc(8'h01, ID);
    rc(8'h11, REV);
    rc(8'h05, 8'h00);
    $display("test read-only done");
  endtask
  // Start-up load, all written before any read so aliasing shows.
  task automatic t_init();
    logic [7:0] a [5] = '{8'h70, 8'h71, 8'hB0, 8'h88, 8'h9A};
    logic [7:0] v [5] = '{8'h8A, 8'h02, 8'h02, 8'h00, 8'h02};
    foreach (a[i]) wr(a[i], v[i]);
    foreach (a[i]) rc(a[i], v[i]);
    $display("test init done");
  endtask
  task automatic t_power();
    wr(8'h04, 8'h00);
    `CHK("power", 1'b0, power_normal_o)
    rc(8'h04, 8'h00);
    wr(8'h04, 8'h02);
    `CHK("power", 1'b1, power_normal_o)
    $display("test power done");
  endtask
  // Every indicator current code, then the shutter driver at a set limit.
  task automatic t_led();
    @(posedge clk_i);
    gain_drive_limit_i <= 2'h2;
    for (int c = 0; c < 4; c++) begin
      wr(8'h84, {4'h0, c[1:0], 2'h1});
      `CHK("indicator", {1'b1, c[1:0]}, {led_o.indicator_on, led_o.indicator_current})
    end
    wr(8'h84, 8'h0C);
    `CHK("indicator_on", 1'b0, led_o.indicator_on)
    wr(8'hEA, 8'h04);
    `CHK("shutter", 3'h6, {led_o.shutter_on, led_o.shutter_limit})
    wr(8'hEA, 8'h00);
    `CHK("shutter_on", 1'b0, led_o.shutter_on)
    $display("test led done");
  endtask
  // Ready flag, interrupt, clearing, and the effect of the enables.
  task automatic t_irq();
    wr(8'h22, 8'hCA);
    wr(8'hF9, 8'h02);
    rc(8'hF8, 8'h04);
    pulse();
    `CHK("irq", 2'h3, {data_ready_o, irq_o})
    wr(8'hF8, 8'h04);
    `CHK("irq", 2'h0, {data_ready_o, irq_o})
    wr(8'hF9, 8'h00);
    wr(8'hF8, 8'h00);
    rc(8'hF8, 8'h00);
    pulse();
    `CHK("ready", 1'b0, data_ready_o)
    wr(8'hF9, 8'h04);
    pulse();
    wr(8'h22, 8'h00);
    `CHK("irq", 2'h2, {data_ready_o, irq_o})
    wr(8'hF9, 8'h00);
    wr(8'hF8, 8'h04);
    `CHK("ready", 1'b1, data_ready_o)
    $display("test irq done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence after sixteen cycles of reset.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_ro();
    t_init();
    t_power();
    t_led();
    t_irq();
    complete_run();
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
endmodule
